// ---- vif_dev.sv ----
// Purpose: Transmitter end: format registers and pixel capture
// Assumes: Pixel clock sampled by I_MCLK, at least 4x slower
// Notes: Space, range and input depth changes apply on write of the last AVI byte
//
// Contract
// R1: Repeat code 0,1,3 gives one,two,four sends
// R2: Falling system control bit 4 clears repeat
// R3: Ratio field selects link clock multiple
// R4: Bus select 1 full, 0 half; reset 1
// R5: Half mode: two edges form one pixel
// R6: Full mode latches on selected edge
// R7: Half mode first half per edge select, high
// R8: Accept 30/36 full, 15/18/24 half widths; half mode here takes only 18 bits per edge
// R9: Reset formats to full-range RGB, zero
// R10: Format selection kept until rewritten or reset
// R11: Format changes pending until AVI last byte; output depth, dither and BT709 apply at once here
// R12: Auto range compresses RGB in, YCbCr out
// R13: Auto range expands YCbCr in, RGB out
// R14: Input range: auto, force, block expansion
// R15: Output range: auto, block, force compression
// R16: Input depth codes; YCbCr only 8 or 12
// R17: Input space code 3 outputs black
// R18: No black mode while protection active; no protection input here, code 3 always gives black
// R19: Output depth field selects 8/16/10/12
// R20: Dither enable bit, conversion standard bit
// R21: Output format 3 behaves as RGB
// R22: Out-of-range clocks need power-down cycling
// R23: Reserved codes stored, previous behaviour kept
//
// Strobed register access was decided locally.
`timescale 1ns/100ps
module vif_dev (
  input wire logic I_MCLK, // System clock
  input wire logic I_RESET_N, // Async reset, active low
  vif_if.dev bus, // Host side
  output logic [35:0] O_PIXEL, // Assembled pixel
  output logic O_PIXEL_VLD, // Pixel strobe, one cycle per send
  output logic [1:0] O_CLK_RATIO, // Link clock ratio
  output logic O_EXPAND, // Range expansion on
  output logic O_COMPRESS, // Range compression on
  output logic O_DITHER, // Dither enable
  output logic O_BT709, // Conversion standard
  output logic [1:0] O_IN_DEPTH, // Effective input depth
  output logic [1:0] O_OUT_DEPTH, // Output depth
  output logic [1:0] O_OUT_SPACE, // Output space code as committed, 3 not mapped to RGB
  output logic O_BLACK // Black mode
);
  logic [7:0] bus_cfg_ff, in_fmt_ff, out_fmt_ff, rdata_ff;
  logic [1:0] in_cs_ff, out_cs_ff, in_rng_ff, out_rng_ff, in_dep_ff;
  logic [3:0] pr_eff_ff;
  logic [2:0] clk_sync_ff;
  logic [35:0] d_sync3_ff;
  logic [35:0] d_sync1_ff, d_sync2_ff, first_ff, pixel_ff;
  logic ctl_sync1_ff, ctl_sync2_ff, ctl_prev_ff, have_first_ff;
  logic [1:0] rep_cnt_ff;
  logic vld_ff, expand_ff, compress_ff, black_ff;
  logic [3:0] nxt_pr_eff;
  logic [1:0] nxt_in_rng, nxt_out_rng, nxt_in_dep;

  function automatic logic ok_range(input logic [1:0] r);
    ok_range = (r != 2'h3);
  endfunction

  wire wr_bus = bus.reg_wr && bus.reg_addr == vif_pkg::ADDR_BUS_CFG;
  wire wr_in = bus.reg_wr && bus.reg_addr == vif_pkg::ADDR_IN_FMT;
  wire wr_out = bus.reg_wr && bus.reg_addr == vif_pkg::ADDR_OUT_FMT;
  wire commit = bus.reg_wr && bus.reg_addr == vif_pkg::ADDR_AVI_LAST; // R11
  wire ctl_fall = ctl_prev_ff && !ctl_sync2_ff; // R2
  wire rise = clk_sync_ff[1] && !clk_sync_ff[2];
  wire fall = !clk_sync_ff[1] && clk_sync_ff[2];
  wire full_mode = bus_cfg_ff[5]; // R4
  wire edge_sel = bus_cfg_ff[4];
  wire [3:0] pr_field = bus_cfg_ff[3:0];
  wire pr_ok = pr_field == vif_pkg::PR_X1 || pr_field == vif_pkg::PR_X2 ||
    pr_field == vif_pkg::PR_X4; // R23
  // Full mode samples on the chosen edge; half mode starts on the opposite-named edge
  wire full_take = full_mode && (edge_sel ? fall : rise); // R6
  wire half_first = !full_mode && (edge_sel ? rise : fall); // R7
  wire half_second = !full_mode && have_first_ff && (edge_sel ? fall : rise); // R5
  // The host launches data with the clock edge, so take the word that stood before it
  wire [35:0] half_pix = {first_ff[17:0], d_sync3_ff[17:0]}; // R7 R8
  wire new_pix = full_take || half_second;
  wire [1:0] out_cs_e = (out_cs_ff == 2'h3) ? vif_pkg::CS_RGB : out_cs_ff; // R21
  wire in_ycc = in_cs_ff == vif_pkg::CS_Y444 || in_cs_ff == vif_pkg::CS_Y422;
  wire out_ycc = out_cs_e != vif_pkg::CS_RGB;
  wire black = in_cs_ff == vif_pkg::CS_BLACK; // R17
  wire [1:0] in_dep_w = in_fmt_ff[7:6];
  // YCbCr input permits 8 or 12 only; anything else keeps the last good depth
  wire dep_ok = !(in_fmt_ff[1:0] == vif_pkg::CS_Y444 || in_fmt_ff[1:0] == vif_pkg::CS_Y422) ||
    in_dep_w == vif_pkg::DEPTH_8 || in_dep_w == vif_pkg::DEPTH_12; // R16
  wire [1:0] rep_max = (pr_eff_ff == vif_pkg::PR_X4) ? 2'h3 :
    (pr_eff_ff == vif_pkg::PR_X2) ? 2'h1 : 2'h0; // R1

  always_comb begin
    nxt_pr_eff = pr_ok ? pr_field : pr_eff_ff; // R23
    nxt_in_rng = ok_range(in_fmt_ff[3:2]) ? in_fmt_ff[3:2] : in_rng_ff; // R23
    nxt_out_rng = ok_range(out_fmt_ff[3:2]) ? out_fmt_ff[3:2] : out_rng_ff; // R23
    nxt_in_dep = dep_ok ? in_dep_w : in_dep_ff;
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      bus_cfg_ff <= vif_pkg::RST_BUS_CFG; // R4
      in_fmt_ff <= vif_pkg::RST_FMT; // R9
      out_fmt_ff <= vif_pkg::RST_FMT; // R9
      rdata_ff <= 8'h00;
    end else begin
      if (wr_bus) bus_cfg_ff <= bus.reg_wdata;
      else if (ctl_fall) bus_cfg_ff <= {bus_cfg_ff[7:4], 4'h0}; // R2
      if (wr_in) in_fmt_ff <= bus.reg_wdata; // R10
      if (wr_out) out_fmt_ff <= bus.reg_wdata; // R10
      rdata_ff <= 8'h00;
      if (bus.reg_rd) begin
        if (bus.reg_addr == vif_pkg::ADDR_BUS_CFG) rdata_ff <= bus_cfg_ff;
        if (bus.reg_addr == vif_pkg::ADDR_IN_FMT) rdata_ff <= in_fmt_ff;
        if (bus.reg_addr == vif_pkg::ADDR_OUT_FMT) rdata_ff <= out_fmt_ff;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Applied settings; repeat code, output depth, dither and BT709 act at once, the rest wait
  always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      in_cs_ff <= vif_pkg::CS_RGB; // R9
      out_cs_ff <= vif_pkg::CS_RGB;
      in_rng_ff <= vif_pkg::RNG_AUTO;
      out_rng_ff <= vif_pkg::RNG_AUTO;
      in_dep_ff <= vif_pkg::DEPTH_8;
      pr_eff_ff <= vif_pkg::PR_X1;
    end else begin
      pr_eff_ff <= nxt_pr_eff;
      if (commit) begin // R11
        in_cs_ff <= in_fmt_ff[1:0];
        out_cs_ff <= out_fmt_ff[1:0];
        in_rng_ff <= nxt_in_rng;
        out_rng_ff <= nxt_out_rng;
        in_dep_ff <= nxt_in_dep;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Two-stage synchronisers; the pixel clock is slow against I_MCLK
  always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      clk_sync_ff <= 3'h0;
      d_sync3_ff <= 36'h0;
      d_sync1_ff <= 36'h0;
      d_sync2_ff <= 36'h0;
      ctl_sync1_ff <= 1'b0;
      ctl_sync2_ff <= 1'b0;
      ctl_prev_ff <= 1'b0;
    end else begin
      clk_sync_ff <= {clk_sync_ff[1:0], bus.pix_clk};
      d_sync3_ff <= d_sync2_ff;
      d_sync1_ff <= bus.pix_data;
      d_sync2_ff <= d_sync1_ff;
      ctl_sync1_ff <= bus.sys_ctl_bit4;
      ctl_sync2_ff <= ctl_sync1_ff;
      ctl_prev_ff <= ctl_sync2_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      first_ff <= 36'h0;
      have_first_ff <= 1'b0;
      pixel_ff <= 36'h0;
      rep_cnt_ff <= 2'h0;
      vld_ff <= 1'b0;
    end else begin
      vld_ff <= 1'b0;
      if (half_first) begin
        first_ff <= d_sync3_ff;
        have_first_ff <= 1'b1;
      end else if (half_second) begin
        have_first_ff <= 1'b0;
      end
      if (new_pix) begin
        pixel_ff <= black ? 36'h0 : (full_mode ? d_sync3_ff : half_pix); // R17
        rep_cnt_ff <= rep_max; // R1
        vld_ff <= 1'b1;
      end else if (rep_cnt_ff != 2'h0) begin
        rep_cnt_ff <= rep_cnt_ff - 2'h1; // R1
        vld_ff <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      expand_ff <= 1'b0;
      compress_ff <= 1'b0;
      black_ff <= 1'b0;
    end else begin
      black_ff <= black; // R17
      expand_ff <= (in_rng_ff == vif_pkg::RNG_ONE) ||
        (in_rng_ff == vif_pkg::RNG_AUTO && in_ycc && !out_ycc); // R13 R14
      compress_ff <= (out_rng_ff == vif_pkg::RNG_TWO) ||
        (out_rng_ff == vif_pkg::RNG_AUTO && !in_ycc && !black && out_ycc); // R12 R15
    end
  end

  assign bus.reg_rdata = rdata_ff;
  assign O_PIXEL = pixel_ff;
  assign O_PIXEL_VLD = vld_ff;
  assign O_CLK_RATIO = bus_cfg_ff[7:6]; // R3
  assign O_EXPAND = expand_ff;
  assign O_COMPRESS = compress_ff;
  assign O_DITHER = out_fmt_ff[5]; // R20
  assign O_BT709 = out_fmt_ff[4]; // R20
  assign O_IN_DEPTH = in_dep_ff; // R16
  assign O_OUT_DEPTH = out_fmt_ff[7:6]; // R19
  assign O_OUT_SPACE = out_cs_ff;
  assign O_BLACK = black_ff;
endmodule

// ---- vif_pkg.sv ----
// Purpose: Shared constants for the video input format block
// Assumes: Byte-wide register port on the device interface
// Notes: Offsets, reset values and field codes of the three format registers
package vif_pkg;
  localparam logic [7:0] ADDR_BUS_CFG = 8'h08;
  localparam logic [7:0] ADDR_IN_FMT = 8'h09;
  localparam logic [7:0] ADDR_OUT_FMT = 8'h0a;
  localparam logic [7:0] ADDR_AVI_LAST = 8'h19;
  localparam logic [7:0] RST_BUS_CFG = 8'h60;
  localparam logic [7:0] RST_FMT = 8'h00;
  localparam int PIX_W = 36;
  localparam int HALF_W = 18;
  localparam logic [3:0] PR_X1 = 4'h0;
  localparam logic [3:0] PR_X2 = 4'h1;
  localparam logic [3:0] PR_X4 = 4'h3;
  localparam logic [1:0] CS_RGB = 2'h0;
  localparam logic [1:0] CS_Y444 = 2'h1;
  localparam logic [1:0] CS_Y422 = 2'h2;
  localparam logic [1:0] CS_BLACK = 2'h3;
  localparam logic [1:0] RNG_AUTO = 2'h0;
  localparam logic [1:0] RNG_ONE = 2'h1;
  localparam logic [1:0] RNG_TWO = 2'h2;
  localparam logic [1:0] DEPTH_8 = 2'h0;
  localparam logic [1:0] DEPTH_16 = 2'h1;
  localparam logic [1:0] DEPTH_12 = 2'h3;
  localparam logic [1:0] RATIO_X1 = 2'h1;
  // Host makes the input pixel clock as a divider of its own clock
  localparam logic [3:0] CLK_HALF_DIV = 4'h3;
endpackage

// ---- vif_if.sv ----
// Purpose: Pixel bus and register port between host and transmitter
// Assumes: Host drives pixel clock and data; both ends share I_MCLK
// Notes: No clocking block
`timescale 1ns/100ps
interface vif_if;
  logic pix_clk;
  logic [vif_pkg::HALF_W*2-1:0] pix_data;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_rdata;
  logic sys_ctl_bit4;
  modport host (output pix_clk, pix_data, reg_addr, reg_wdata, reg_wr, reg_rd, sys_ctl_bit4,
    input reg_rdata);
  modport dev (input pix_clk, pix_data, reg_addr, reg_wdata, reg_wr, reg_rd, sys_ctl_bit4,
    output reg_rdata);
endinterface

// ---- vif_host.sv ----
// Purpose: Video host end: pixel clock, half/full pixel drive, register writes
// Assumes: One register request at a time from the user port
// Notes: Pixel clock is I_MCLK divided down
`timescale 1ns/100ps
module vif_host (
  input wire logic I_MCLK, // System clock
  input wire logic I_RESET_N, // Async reset, active low
  vif_if.host bus, // Device side
  input wire logic I_FULL_MODE, // 1 full pixel, 0 half pixel
  input wire logic I_EDGE_SEL, // Edge select, as programmed
  input wire logic [35:0] I_PIXEL, // Pixel to send
  output logic O_PIXEL_TAKE, // Pixel consumed, one cycle
  input wire logic I_WR, // Register write request
  input wire logic I_RD, // Register read request
  input wire logic [7:0] I_ADDR, // Register address
  input wire logic [7:0] I_WDATA, // Write data
  output logic [7:0] O_RDATA, // Read data, two cycles after I_RD
  input wire logic I_SYS_CTL4 // System control bit 4 level
);
  logic [3:0] div_ff;
  logic pclk_ff, wr_ff, rd_ff, ctl_ff, take_ff;
  logic [7:0] addr_ff, wdata_ff;
  logic [35:0] pix_ff, out_ff;
  // Fixed divider keeps the pixel clock inside its permitted range
  wire tick = div_ff == vif_pkg::CLK_HALF_DIV; // R22
  wire rising = tick && !pclk_ff;
  // Half mode: first half (high bits) before edge chosen by edge select
  wire first_edge = I_EDGE_SEL ? rising : (tick && pclk_ff); // R7
  wire second_edge = I_EDGE_SEL ? (tick && pclk_ff) : rising;

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      div_ff <= 4'h0;
      pclk_ff <= 1'b0;
      pix_ff <= 36'h0;
      out_ff <= 36'h0;
      take_ff <= 1'b0;
    end else begin
      div_ff <= tick ? 4'h0 : div_ff + 4'h1;
      take_ff <= 1'b0;
      if (tick) pclk_ff <= !pclk_ff;
      if (I_FULL_MODE) begin
        // Data changes on the opposite edge, stable around the latch edge
        if (I_EDGE_SEL ? rising : (tick && pclk_ff)) begin // R6
          out_ff <= I_PIXEL;
          take_ff <= 1'b1;
        end
      end else if (second_edge) begin // R5
        pix_ff <= I_PIXEL;
        out_ff <= {18'h0, I_PIXEL[35:18]};
        take_ff <= 1'b1;
      end else if (first_edge) begin
        out_ff <= {18'h0, pix_ff[17:0]};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      wr_ff <= 1'b0;
      rd_ff <= 1'b0;
      addr_ff <= 8'h00;
      wdata_ff <= 8'h00;
      ctl_ff <= 1'b0;
    end else begin
      wr_ff <= I_WR; // R3
      rd_ff <= I_RD && !I_WR;
      addr_ff <= I_ADDR;
      wdata_ff <= I_WDATA;
      ctl_ff <= I_SYS_CTL4;
    end
  end

  assign bus.pix_clk = pclk_ff;
  assign bus.pix_data = out_ff;
  assign bus.reg_addr = addr_ff;
  assign bus.reg_wdata = wdata_ff;
  assign bus.reg_wr = wr_ff;
  assign bus.reg_rd = rd_ff;
  assign bus.sys_ctl_bit4 = ctl_ff;
  assign O_RDATA = bus.reg_rdata;
  assign O_PIXEL_TAKE = take_ff;
endmodule

// ---- vif_chk.sv ----
// Purpose: Interface checker for the host to transmitter link
// Assumes: Both ends share I_MCLK; pixel clock is I_MCLK over 8
// Notes: Sees only the interface signals
`timescale 1ns/100ps
module vif_chk (
  input wire logic I_MCLK, // Clock
  input wire logic I_RESET_N, // Reset, active low
  input wire logic pix_clk, // Pixel clock
  input wire logic [vif_pkg::HALF_W*2-1:0] pix_data, // Pixel data
  input wire logic [7:0] reg_addr, // Address
  input wire logic [7:0] reg_wdata, // Write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  input wire logic [7:0] reg_rdata, // Read data
  input wire logic sys_ctl_bit4 // System control bit 4
);
  default clocking cb @(posedge I_MCLK);
  endclocking
  default disable iff (!I_RESET_N);
  logic [2:0] wseen_ff;
  logic [2:0] clr_cnt_ff;
  wire [2:0] wr_hit = {3{reg_wr}} & {reg_addr == vif_pkg::ADDR_OUT_FMT,
    reg_addr == vif_pkg::ADDR_IN_FMT, reg_addr == vif_pkg::ADDR_BUS_CFG};
  wire map_hit = reg_addr == vif_pkg::ADDR_BUS_CFG || reg_addr == vif_pkg::ADDR_IN_FMT ||
    reg_addr == vif_pkg::ADDR_OUT_FMT;
  ////////
  // Cycles since bit 4 fell; a bus config write clears it to 0, saturates at 7
  always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      wseen_ff <= 3'h0;
      clr_cnt_ff <= 3'h0;
    end else begin
      wseen_ff <= wseen_ff | wr_hit;
      if (wr_hit[0]) clr_cnt_ff <= 3'h0;
      else if ($fell(sys_ctl_bit4)) clr_cnt_ff <= 3'h1;
      else if (clr_cnt_ff != 3'h0 && clr_cnt_ff != 3'h7) clr_cnt_ff <= clr_cnt_ff + 3'h1;
    end
  end
  ////////
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside an answer");
  a_unmapped_zero: assert property (reg_rd && !map_hit |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_strobe_excl: assert property (!(reg_wr && reg_rd))
    else $error("both strobes high");
  a_write_kept: assert property (reg_wr && map_hit ##1 reg_rd && $stable(reg_addr) &&
    clr_cnt_ff == 3'h0 |=> reg_rdata == $past(reg_wdata, 2))
    else $error("readback differs from write");
  a_reset_vals: assert property (reg_rd && map_hit && !wseen_ff[reg_addr[1:0]] |=>
    reg_rdata == ($past(reg_addr) == vif_pkg::ADDR_BUS_CFG ? vif_pkg::RST_BUS_CFG :
    vif_pkg::RST_FMT))
    else $error("register not at reset value");
  a_pr_clear: assert property (reg_rd && reg_addr == vif_pkg::ADDR_BUS_CFG &&
    clr_cnt_ff >= 3'h5 |=> reg_rdata[3:0] == 4'h0)
    else $error("repeat field not cleared");
  a_clk_high: assert property ($rose(pix_clk) |-> pix_clk[*4] ##1 !pix_clk)
    else $error("pixel clock high phase wrong");
  a_clk_low: assert property ($fell(pix_clk) |-> (!pix_clk)[*4] ##1 pix_clk)
    else $error("pixel clock low phase wrong");
endmodule

// ---- video_input_format_config_tb.sv ----
// Purpose: Self-checking bench for the video input format block
// Assumes: Host and transmitter ends share one clock
// Notes: All traffic enters through the host user port
`timescale 1ns/100ps
module video_input_format_config_tb;
  logic clk, rst_n, full, esel, wr, rd, sys4;
  logic [7:0] addr, wdata, rdata;
  logic [35:0] pix, o_pixel;
  logic vld, expand, compress, dither, bt709, black;
  logic [1:0] ratio, in_depth, out_depth, out_space;
  int n_errors = 0;
  int n_compared = 0;
  logic [7:0] tin [8] = '{8'h80, 8'h01, 8'h01, 8'h09, 8'h04, 8'h0d, 8'hc3, 8'h41};
  logic [7:0] tout [8] = '{8'h01, 8'h00, 8'h03, 8'h08, 8'h05, 8'h0d, 8'h00, 8'h00};
  logic [6:0] texp [8] = '{7'h26, 7'h40, 7'h4c, 7'h20, 7'h44, 7'h44, 7'h13, 7'h43};
  logic [6:0] prev;
  logic [35:0] held;
  wire [6:0] eff = {expand, compress, black, out_space, in_depth};
  vif_if vif();
  vif_dev vif_dev_inst (.I_MCLK(clk), .I_RESET_N(rst_n), .bus(vif), .O_PIXEL(o_pixel),
    .O_PIXEL_VLD(vld), .O_CLK_RATIO(ratio), .O_EXPAND(expand), .O_COMPRESS(compress),
    .O_DITHER(dither), .O_BT709(bt709), .O_IN_DEPTH(in_depth), .O_OUT_DEPTH(out_depth),
    .O_OUT_SPACE(out_space), .O_BLACK(black));
  vif_host vif_host_inst (.I_MCLK(clk), .I_RESET_N(rst_n), .bus(vif), .I_FULL_MODE(full),
    .I_EDGE_SEL(esel), .I_PIXEL(pix), .O_PIXEL_TAKE(), .I_WR(wr), .I_RD(rd), .I_ADDR(addr),
    .I_WDATA(wdata), .O_RDATA(rdata), .I_SYS_CTL4(sys4));
  vif_chk vif_chk_inst (.I_MCLK(clk), .I_RESET_N(rst_n), .pix_clk(vif.pix_clk),
    .pix_data(vif.pix_data), .reg_addr(vif.reg_addr), .reg_wdata(vif.reg_wdata),
    .reg_wr(vif.reg_wr), .reg_rd(vif.reg_rd), .reg_rdata(vif.reg_rdata),
    .sys_ctl_bit4(vif.sys_ctl_bit4));
  ////////
  task automatic end_sim;
    if (n_errors == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [35:0] s, input logic [35:0] e);
    n_compared++;
    if (s !== e) begin
      n_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // Called just after an edge; the strobe drops one edge later
  task automatic wrr(input logic [7:0] a, input logic [7:0] d);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // Host adds one cycle, so the answer shows two edges after the request
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    #1;
    chk(36'(rdata), 36'(e));
  endtask
  task automatic settle;
    repeat (4) @(posedge clk);
    #1;
  endtask
  // Bursts repeat every 8 cycles, so any 64-cycle window holds 8 of them
  task automatic cnt_vld(input int n);
    int c = 0;
    repeat (16) @(negedge clk);
    repeat (64) begin
      @(negedge clk);
      c += int'(vld === 1'b1);
    end
    chk(36'(c), 36'(8 * n));
    @(posedge clk);
  endtask
  // Bus word that stood just before the next pixel clock edge toward level tgt
  task automatic held_at(input logic tgt);
    logic pc;
    int k = 0;
    @(negedge clk);
    pc = vif.pix_clk;
    held = vif.pix_data;
    @(negedge clk);
    while (!(vif.pix_clk === tgt && pc !== tgt) && k < 40) begin
      pc = vif.pix_clk;
      held = vif.pix_data;
      @(negedge clk);
      k++;
    end
  endtask
  task automatic wvld(input logic [35:0] e);
    int k = 0;
    repeat (24) @(negedge clk);
    while (vld !== 1'b1 && k < 40) begin
      @(negedge clk);
      k++;
    end
    chk(o_pixel, e);
    @(posedge clk);
  endtask
  ////////
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // The run needs about 800 cycles; this allows about 25 times that
  initial begin
    #500000;
    n_errors++;
    end_sim();
  end
  initial begin
    rst_n = 1'b0;
    {full, esel, wr, rd, sys4, addr, wdata} = {1'b1, 20'h0};
    pix = 36'h9_8765_4321;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk(36'(ratio), 36'h1);
    rdc(8'h08, 8'h60);
    rdc(8'h09, 8'h00);
    rdc(8'h0a, 8'h00);
    wrr(8'h30, 8'hff);
    rdc(8'h30, 8'h00);
    for (int r = 0; r < 4; r++) begin
      wrr(8'h08, {2'(r), 6'h20});
      rdc(8'h08, {2'(r), 6'h20});
      chk(36'(ratio), 36'(r));
    end
    for (int d = 0; d < 4; d++) begin
      wrr(8'h0a, {2'(d), 2'(d), 4'h0});
      settle();
      chk(36'({out_depth, dither, bt709}), 36'({2'(d), 2'(d)}));
    end
    prev = 7'h00;
    for (int i = 0; i < 8; i++) begin
      wrr(8'h09, tin[i]);
      rdc(8'h09, tin[i]);
      wrr(8'h0a, tout[i]);
      rdc(8'h0a, tout[i]);
      settle();
      chk(36'(eff), 36'(prev));
      wrr(vif_pkg::ADDR_AVI_LAST, 8'h00);
      settle();
      chk(36'(eff), 36'(texp[i]));
      prev = texp[i];
    end
    for (int p = 0; p < 3; p++) begin
      wrr(8'h08, {4'h6, 4'(p + p / 2)});
      cnt_vld(1 << p);
    end
    wrr(8'h08, 8'h65);
    rdc(8'h08, 8'h65);
    cnt_vld(4);
    sys4 <= 1'b1;
    repeat (8) @(posedge clk);
    sys4 <= 1'b0;
    repeat (8) @(posedge clk);
    rdc(8'h08, 8'h60);
    cnt_vld(1);
    // Full rising, full falling, half falling first, half rising first
    for (int m = 0; m < 4; m++) begin
      full <= ~m[1];
      esel <= m[0];
      wrr(8'h08, {2'h1, ~m[1], m[0], 4'h0});
      wvld(pix);
      held_at(m[0] ^ ~m[1]);
      chk(m[1] ? 36'(held[17:0]) : held, m[1] ? 36'(pix[35:18]) : pix);
      @(posedge clk);
    end
    wrr(8'h09, 8'h03);
    rdc(8'h09, 8'h03);
    wrr(vif_pkg::ADDR_AVI_LAST, 8'h00);
    wvld(36'h0);
    end_sim();
  end
endmodule
